//--- fpe_consts.svh
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register port
`ifndef FPE_CONSTS_SVH
`define FPE_CONSTS_SVH

`define FPE_OFF_MAIN_KEY      8'h04
`define FPE_OFF_OPT_KEY       8'h08
`define FPE_OFF_STATUS        8'h0C
`define FPE_OFF_CONTROL       8'h10
`define FPE_OFF_ADDRESS       8'h14

`define FPE_ST_BUSY           0
`define FPE_ST_PROGRAM_ERROR_FLAG          2
`define FPE_ST_WPERR          4
`define FPE_ST_DONE           5
`define FPE_ST_PATERR         8
`define FPE_ST_CONFIG_MISMATCH_FLAG         9

`define FPE_CT_PROG           0
`define FPE_CT_PAGE           1
`define FPE_CT_MASS           2
`define FPE_CT_OPTPROG        4
`define FPE_CT_OPTERASE       5
`define FPE_CT_START          6
`define FPE_CT_LOCK           7
`define FPE_CT_PARTIAL        8
`define FPE_CT_OPTION_WRITE_ENABLE          9
`define FPE_CT_ERRIE          10
`define FPE_CT_DONEIE         12

`define FPE_CT_WMASK          32'h0000_17F7
`define FPE_CT_RESET          32'h0000_0080
`define FPE_ST_RESET          32'h0000_0000
`define FPE_ERASED_WORD       32'hFFFF_FFFF
`define FPE_PARTIAL_PAGES     16'h0030

`define FPE_KEY1_DEFAULT      32'h1234_5678
`define FPE_KEY2_DEFAULT      32'h9ABC_DEF0

`define FPE_CLK_MHZ           50
`define FPE_PROG_NS           1000
`define FPE_ERASE_NS          4000
`define FPE_PROG_CYC          ((`FPE_PROG_NS * `FPE_CLK_MHZ + 999) / 1000)
`define FPE_ERASE_CYC         ((`FPE_ERASE_NS * `FPE_CLK_MHZ + 999) / 1000)

`endif

//--- fpe_flash_array.sv
// behavioural flash array on the far side of the controller
// assumes word index in arrayAddr[7:2], protected from PROT_BASE up
`timescale 1ns/1ps
`include "fpe_consts.svh"
module fpe_flash_array #(
    parameter logic [31:0] PROT_BASE = 32'h0000_0100
)(
    // clock
    input  wire logic        clk,
    // controller side
    input  wire logic [31:0] arrayAddr,
    input  wire logic [31:0] arrayWdata,
    input  wire logic        arrayProg,
    input  wire logic        arrayErase,
    // answers
    output logic [31:0]      arrayRdata,
    output logic             arrayProtected
);
    logic [31:0] mem [0:63];
    initial
    begin
        foreach (mem[i]) mem[i] = `FPE_ERASED_WORD;
        mem[3] = 32'h0000_0000;
    end
    // any erase wipes every word, harsher than one page
    always @(posedge clk)
    begin
        if (arrayProg) mem[arrayAddr[7:2]] <= arrayWdata;
        if (arrayErase) foreach (mem[i]) mem[i] <= `FPE_ERASED_WORD;
    end
    assign arrayRdata     = mem[arrayAddr[7:2]];
    assign arrayProtected = (arrayAddr >= PROT_BASE);
endmodule : fpe_flash_array

//--- fpe_flash_ctrl.sv
// flash program/erase control: key unlock, status, control and address registers
// assumes an AXI4-Lite master on clk and a simple word-wide flash array port
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fpe_consts.svh"

// Functional notes
// [R1] option key register unlocks option bytes
// [R2] status bit 9 flags configuration mismatch
// [R3] status bit 8 flags pattern mismatch
// [R4] bit 5 done flag, write one clears
// [R5] bit 4 flags write to protected address
// [R6] bit 2 flags program of unerased word
// [R7] software clears start before programming; writes here cannot clear start, the sequencer clears it at launch
// [R8] busy high during operation, low after
// [R9] control bit 12 enables done interrupt
// [R10] control bit 10 enables error interrupt
// [R11] correct option key sets option enable
// [R12] partial erase covers first 48 pages
// [R13] lock bit write-one only, blocks changes
// [R14] correct main key clears lock
// [R15] failed unlock freezes lock until reset
// [R16] start launches erase, cleared at busy
// [R17] bits 5 and 4 select option modes
// [R18] mass erase clears whole main array
// [R19] bit 0 selects program mode
// [R20] reset: control 0x80, status zero
// [R21] main key register at offset 0x04
// [R22] address register ignored while busy
// [R23] page erase clears addressed page
// [R24] key values are parameters, mismatch fails
module fpe_flash_ctrl
    import fpe_pkg::*;
#(
    parameter logic [31:0] MAIN_KEY1 = `FPE_KEY1_DEFAULT,
    parameter logic [31:0] MAIN_KEY2 = `FPE_KEY2_DEFAULT,
    parameter logic [31:0] OPT_KEY1  = `FPE_KEY1_DEFAULT,
    parameter logic [31:0] OPT_KEY2  = `FPE_KEY2_DEFAULT,
    parameter int          PAGE_SHIFT = 9,
    parameter logic [15:0] PAGE_COUNT = 16'h0040
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // program request from the memory bus
    input  wire logic        progReq,
    input  wire logic [31:0] progData,
    // array side
    input  wire logic [31:0] arrayRdata,
    input  wire logic        arrayProtected,
    output logic             arrayProg,
    output logic             arrayErase,
    output logic             arrayOpt,
    output logic [31:0]      arrayAddr,
    output logic [31:0]      arrayWdata,
    // configuration checks
    input  wire logic        cfgMismatch,
    input  wire logic        patternMismatch,
    // interrupts
    output logic             doneIrq,
    output logic             errIrq
);

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [7:0]  awaddr;
        logic        awHave;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wHave;
        logic [31:0] control;
        logic [31:0] status;
        logic [31:0] address;
        logic [31:0] wordData;
        logic [31:0] outAddr;
        fpe_state_t  state;
        logic [15:0] count;
        logic [15:0] page;
        logic [15:0] pageEnd;
        fpe_key_t    mainKey;
        fpe_key_t    option_key_value;
        logic        lockFrozen;
        logic        prog;
        logic        erase;
        logic        opt;
        logic        doneIrq;
        logic        errIrq;
    } fpe_regs_t;

    fpe_regs_t st_r;
    fpe_regs_t st_nxt;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction : merge

    localparam logic [15:0] PROG_CYC  = 16'(`FPE_PROG_CYC);
    localparam logic [15:0] ERASE_CYC = 16'(`FPE_ERASE_CYC);

    logic        wrFire;
    logic [31:0] wv;
    logic        locked;
    logic        startSeen;

    always_comb
    begin
        st_nxt    = st_r;
        wrFire    = 1'b0;
        wv        = 32'h0000_0000;
        locked    = st_r.control[`FPE_CT_LOCK];
        startSeen = 1'b0;

        // write channel capture, either order
        if (s_axi_awvalid && st_r.awready)
        begin
            st_nxt.awaddr  = s_axi_awaddr;
            st_nxt.awHave  = 1'b1;
            st_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && st_r.wready)
        begin
            st_nxt.wdata  = s_axi_wdata;
            st_nxt.wstrb  = s_axi_wstrb;
            st_nxt.wHave  = 1'b1;
            st_nxt.wready = 1'b0;
        end
        if (st_r.awHave && st_r.wHave && !st_r.bvalid)
        begin
            wrFire        = 1'b1;
            st_nxt.awHave = 1'b0;
            st_nxt.wHave  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = 2'b00;
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid  = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready  = 1'b1;
        end

        st_nxt.status[`FPE_ST_CONFIG_MISMATCH_FLAG] = cfgMismatch;     // see [R2]
        st_nxt.status[`FPE_ST_PATERR] = patternMismatch; // see [R3]

        if (wrFire)
        begin
            wv = merge(32'h0000_0000, st_r.wdata, st_r.wstrb);
            unique case (st_r.awaddr)
                `FPE_OFF_STATUS: // write one clears; a set by the sequencer below wins
                begin
                    if (wv[`FPE_ST_DONE])
                        st_nxt.status[`FPE_ST_DONE] = 1'b0;   // see [R4]
                    if (wv[`FPE_ST_WPERR])
                        st_nxt.status[`FPE_ST_WPERR] = 1'b0;  // see [R5]
                    if (wv[`FPE_ST_PROGRAM_ERROR_FLAG])
                        st_nxt.status[`FPE_ST_PROGRAM_ERROR_FLAG] = 1'b0;  // see [R6]
                end
                `FPE_OFF_MAIN_KEY:
                begin
                    if (!st_r.lockFrozen && locked)
                    begin
                        st_nxt.mainKey = FPE_KEY_WAIT1;
                        if (st_r.mainKey == FPE_KEY_WAIT1 && wv == MAIN_KEY1)
                            st_nxt.mainKey = FPE_KEY_WAIT2;
                        else if (st_r.mainKey == FPE_KEY_WAIT2 && wv == MAIN_KEY2)
                            st_nxt.control[`FPE_CT_LOCK] = 1'b0; // see [R14] [R21] [R24]
                        else
                            st_nxt.lockFrozen = 1'b1;            // see [R15] [R24]
                    end
                end
                `FPE_OFF_OPT_KEY:
                begin
                    st_nxt.option_key_value = FPE_KEY_WAIT1;
                    if (st_r.option_key_value == FPE_KEY_WAIT1 && wv == OPT_KEY1)
                        st_nxt.option_key_value = FPE_KEY_WAIT2;
                    else if (st_r.option_key_value == FPE_KEY_WAIT2 && wv == OPT_KEY2 && !locked)
                        st_nxt.control[`FPE_CT_OPTION_WRITE_ENABLE] = 1'b1; // see [R1] [R11]
                end
                `FPE_OFF_CONTROL:
                begin
                    wv = merge(st_r.control, st_r.wdata, st_r.wstrb);
                    if (!locked)
                    begin
                        // option enable may only be cleared here
                        st_nxt.control = (wv & `FPE_CT_WMASK)
                            | (st_r.control & ~`FPE_CT_WMASK);
                        st_nxt.control[`FPE_CT_OPTION_WRITE_ENABLE] = st_r.control[`FPE_CT_OPTION_WRITE_ENABLE] & wv[`FPE_CT_OPTION_WRITE_ENABLE]; // see [R11]
                        st_nxt.control[`FPE_CT_START] = st_r.control[`FPE_CT_START] | wv[`FPE_CT_START]; // see [R16]
                        startSeen = wv[`FPE_CT_START];
                    end
                    // lock is write-one only and frozen after a failed key
                    if (wv[`FPE_CT_LOCK] && !st_r.lockFrozen)
                        st_nxt.control[`FPE_CT_LOCK] = 1'b1; // see [R13]
                end
                `FPE_OFF_ADDRESS:
                begin
                    if (!st_r.status[`FPE_ST_BUSY])
                        st_nxt.address = merge(st_r.address, st_r.wdata, st_r.wstrb); // see [R22]
                end
                default:
                begin
                    st_nxt.bresp = 2'b10;
                end
            endcase
        end

        // operation sequencer
        st_nxt.prog  = 1'b0;
        st_nxt.erase = 1'b0;
        st_nxt.opt   = 1'b0;
        unique case (st_r.state)
            FPE_IDLE:
            begin
                if (!locked && st_r.control[`FPE_CT_START])
                begin
                    st_nxt.control[`FPE_CT_START] = 1'b0;     // see [R16]
                    st_nxt.count = ERASE_CYC;
                    st_nxt.page  = 16'h0000;
                    if (st_r.control[`FPE_CT_OPTERASE] && st_r.control[`FPE_CT_OPTION_WRITE_ENABLE])
                        st_nxt.state = FPE_OPT;               // see [R17]
                    else if (st_r.control[`FPE_CT_MASS])
                    begin
                        st_nxt.pageEnd = PAGE_COUNT;          // see [R18]
                        st_nxt.state   = FPE_ERASE_RANGE;
                    end
                    else if (st_r.control[`FPE_CT_PARTIAL])
                    begin
                        st_nxt.pageEnd = `FPE_PARTIAL_PAGES;  // see [R12]
                        st_nxt.state   = FPE_ERASE_RANGE;
                    end
                    else if (st_r.control[`FPE_CT_PAGE])
                    begin
                        st_nxt.page  = 16'(st_r.address >> PAGE_SHIFT); // see [R23]
                        st_nxt.state = FPE_ERASE_PAGE;
                    end
                    st_nxt.status[`FPE_ST_BUSY] = (st_nxt.state != FPE_IDLE); // see [R8]
                end
                else if (progReq && !locked && !startSeen && !st_r.control[`FPE_CT_START]
                         && (st_r.control[`FPE_CT_PROG]
                             || (st_r.control[`FPE_CT_OPTPROG] && st_r.control[`FPE_CT_OPTION_WRITE_ENABLE]))) // see [R7] [R19] [R17]
                begin
                    if (arrayProtected)
                        st_nxt.status[`FPE_ST_WPERR] = 1'b1;  // see [R5]
                    else if (arrayRdata != `FPE_ERASED_WORD)
                        st_nxt.status[`FPE_ST_PROGRAM_ERROR_FLAG] = 1'b1;  // see [R6]
                    else
                    begin
                        st_nxt.wordData = progData;
                        st_nxt.status[`FPE_ST_BUSY] = 1'b1;   // see [R8]
                        st_nxt.count = PROG_CYC;
                        st_nxt.state = FPE_PROG;
                    end
                end
            end
            FPE_PROG, FPE_ERASE_PAGE, FPE_OPT, FPE_ERASE_RANGE:
            begin
                st_nxt.prog  = (st_r.state == FPE_PROG);
                st_nxt.erase = (st_r.state == FPE_ERASE_PAGE) || (st_r.state == FPE_ERASE_RANGE);
                st_nxt.opt   = (st_r.state == FPE_OPT) || st_r.control[`FPE_CT_OPTPROG];
                if (st_r.count > 16'h0001)
                    st_nxt.count = st_r.count - 16'h0001;
                else if (st_r.state == FPE_ERASE_RANGE
                         && st_r.page + 16'h0001 < st_r.pageEnd)
                begin
                    st_nxt.page  = st_r.page + 16'h0001;
                    st_nxt.count = ERASE_CYC;
                end
                else
                begin
                    st_nxt.status[`FPE_ST_BUSY] = 1'b0;       // see [R8]
                    st_nxt.status[`FPE_ST_DONE] = 1'b1;       // see [R4]
                    st_nxt.state = FPE_IDLE;
                end
            end
        endcase

        st_nxt.doneIrq = st_nxt.status[`FPE_ST_DONE] & st_nxt.control[`FPE_CT_DONEIE]; // see [R9]
        st_nxt.errIrq  = (st_nxt.status[`FPE_ST_PROGRAM_ERROR_FLAG] | st_nxt.status[`FPE_ST_WPERR])
                         & st_nxt.control[`FPE_CT_ERRIE];                                // see [R10]
        // array sees the target word outside erases, so idle checks read it
        st_nxt.outAddr = (st_nxt.state == FPE_ERASE_PAGE || st_nxt.state == FPE_ERASE_RANGE)
                         ? {16'h0000, st_nxt.page} : st_nxt.address;

        // read channel
        if (s_axi_arvalid && st_r.arready)
        begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid  = 1'b1;
            st_nxt.rresp   = 2'b00;
            unique case (s_axi_araddr)
                `FPE_OFF_STATUS:   st_nxt.rdata = st_r.status;
                `FPE_OFF_CONTROL:  st_nxt.rdata = st_r.control;
                `FPE_OFF_ADDRESS:  st_nxt.rdata = st_r.address;
                `FPE_OFF_MAIN_KEY,
                `FPE_OFF_OPT_KEY:  st_nxt.rdata = 32'h0000_0000;
                default:
                begin
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.rresp = 2'b10;
                end
            endcase
        end
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid  = 1'b0;
            st_nxt.arready = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r         <= '0;
            st_r.awready <= 1'b1;
            st_r.wready  <= 1'b1;
            st_r.arready <= 1'b1;
            st_r.control <= `FPE_CT_RESET;   // see [R20]
            st_r.status  <= `FPE_ST_RESET;
        end
        else
            st_r <= st_nxt;
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rresp   = st_r.rresp;
    assign s_axi_rdata   = st_r.rdata;
    assign arrayProg     = st_r.prog;
    assign arrayErase    = st_r.erase;
    assign arrayOpt      = st_r.opt;
    assign arrayAddr     = st_r.outAddr;
    assign arrayWdata    = st_r.wordData;
    assign doneIrq       = st_r.doneIrq;
    assign errIrq        = st_r.errIrq;

    AST_DONE_IRQ: assert property (@(posedge clk) disable iff (rst) // see [R9]
        doneIrq == (st_r.status[`FPE_ST_DONE] && st_r.control[`FPE_CT_DONEIE]))
        else $error("done interrupt wrong");
    AST_ERR_IRQ: assert property (@(posedge clk) disable iff (rst) // see [R10]
        errIrq |-> st_r.control[`FPE_CT_ERRIE] && (st_r.status[`FPE_ST_PROGRAM_ERROR_FLAG] || st_r.status[`FPE_ST_WPERR]))
        else $error("error interrupt without cause");
    AST_BUSY_IDLE: assert property (@(posedge clk) disable iff (rst) // see [R8]
        st_r.status[`FPE_ST_BUSY] == (st_r.state != FPE_IDLE))
        else $error("busy disagrees with sequencer");
    AST_START_CLR: assert property (@(posedge clk) disable iff (rst) // see [R16]
        $rose(st_r.status[`FPE_ST_BUSY]) && st_r.state != FPE_PROG |-> !st_r.control[`FPE_CT_START])
        else $error("start not cleared at busy");
    AST_FROZEN: assert property (@(posedge clk) disable iff (rst) // see [R15]
        st_r.lockFrozen |=> $stable(st_r.control[`FPE_CT_LOCK]))
        else $error("lock changed while frozen");
    AST_ADDR_BUSY: assert property (@(posedge clk) disable iff (rst) // see [R22]
        st_r.status[`FPE_ST_BUSY] && st_r.state != FPE_IDLE |=> $stable(st_r.address) || !$past(st_r.status[`FPE_ST_BUSY]))
        else $error("address changed while busy");
    AST_CFG: assert property (@(posedge clk) disable iff (rst) // see [R2]
        ##1 st_r.status[`FPE_ST_CONFIG_MISMATCH_FLAG] == $past(cfgMismatch))
        else $error("config flag wrong");
    AST_PAT: assert property (@(posedge clk) disable iff (rst) // see [R3]
        ##1 st_r.status[`FPE_ST_PATERR] == $past(patternMismatch))
        else $error("pattern flag wrong");
    AST_DONE_SET: assert property (@(posedge clk) disable iff (rst) // see [R4]
        $fell(st_r.status[`FPE_ST_BUSY]) |-> st_r.status[`FPE_ST_DONE])
        else $error("done flag not set");

endmodule : fpe_flash_ctrl

//--- fpe_pkg.sv
// types for the flash program and erase controller
// assumes fpe_consts.svh carries all numbers
package fpe_pkg;

    typedef enum logic [2:0] {
        FPE_IDLE,
        FPE_PROG,
        FPE_ERASE_PAGE,
        FPE_ERASE_RANGE,
        FPE_OPT
    } fpe_state_t;

    typedef enum logic [1:0] {
        FPE_KEY_WAIT1,
        FPE_KEY_WAIT2
    } fpe_key_t;

endpackage : fpe_pkg

//--- tb_top.sv
// self-checking bench for the flash program/erase controller
// assumes default key parameters and the behavioural array model
`timescale 1ns/1ps
`include "fpe_consts.svh"
module tb_top;
    localparam logic [7:0] CT = `FPE_OFF_CONTROL;
    localparam logic [7:0] ST = `FPE_OFF_STATUS;
    localparam logic [31:0] K1 = `FPE_KEY1_DEFAULT;
    localparam logic [31:0] K2 = `FPE_KEY2_DEFAULT;
    logic clk = 0, rst = 1, awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
    logic awReady, wReady, bValid, arReady, rValid, arrayProtected, arrayProg, arrayErase, arrayOpt;
    logic progReq = 0, cfgMismatch = 0, patternMismatch = 0, doneIrq, errIrq;
    logic [7:0]  awAddr = 0, arAddr = 0;
    logic [31:0] wData = 0, progData = 0, rData, arrayRdata, arrayAddr, arrayWdata;
    logic [1:0]  bResp, rResp;
    int miscompares = 0, checks = 0, cycles = 0, eraseCycles = 0;
    always #10 clk = ~clk;
    fpe_flash_ctrl dut (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .progReq(progReq),
        .progData(progData), .arrayRdata(arrayRdata), .arrayProtected(arrayProtected),
        .arrayProg(arrayProg), .arrayErase(arrayErase), .arrayOpt(arrayOpt), .arrayAddr(arrayAddr),
        .arrayWdata(arrayWdata), .cfgMismatch(cfgMismatch), .patternMismatch(patternMismatch),
        .doneIrq(doneIrq), .errIrq(errIrq));
    fpe_flash_array flash (.clk(clk), .arrayAddr(arrayAddr), .arrayWdata(arrayWdata),
        .arrayProg(arrayProg), .arrayErase(arrayErase), .arrayRdata(arrayRdata),
        .arrayProtected(arrayProtected));
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (arrayErase) eraseCycles <= eraseCycles + 1;
        if (cycles == 60000)
        begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmpWord
    task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
        cmpWord({30'h0, got}, {30'h0, exp});
    endtask : cmpResp
    // handshakes judged on what each rising edge samples; bReady and rReady stay high
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awHs, wHs, bHs;
        bHs = 0;
        awAddr <= a;
        wData <= d;
        awValid <= 1;
        wValid <= 1;
        bReady <= 1;
        while (!bHs)
        begin
            @(posedge clk);
            awHs = awValid && awReady;
            wHs = wValid && wReady;
            bHs = bValid === 1;
            r = bResp;
            if (awHs) awValid <= 0;
            if (wHs) wValid <= 0;
        end
    endtask : axiWr
    task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic arHs, rHs;
        rHs = 0;
        arAddr <= a;
        arValid <= 1;
        rReady <= 1;
        while (!rHs)
        begin
            @(posedge clk);
            arHs = arValid && arReady;
            rHs = rValid === 1;
            d = rData;
            r = rResp;
            if (arHs) arValid <= 0;
        end
    endtask : axiRd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axiWr(a, d, r);
        cmpResp(r, 2'b00);
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axiRd(a, d, r);
        cmpWord(d & m, e);
    endtask : rdChk
    task automatic waitIdle();
        logic [31:0] d;
        logic [1:0] r;
        d = 1;
        while (d[0] !== 1'b0) axiRd(ST, d, r);
    endtask : waitIdle
    task automatic progTry(input logic [31:0] a, input logic [31:0] d);
        wr(`FPE_OFF_ADDRESS, a);
        progData <= d;
        progReq <= 1;
        @(posedge clk);
        progReq <= 0;
        repeat (3) @(posedge clk);
    endtask : progTry
    task automatic testRegs();
        logic [31:0] d;
        logic [1:0] r;
        rdChk(CT, 32'hFFFF_FFFF, `FPE_CT_RESET);
        rdChk(ST, 32'hFFFF_FFFF, `FPE_ST_RESET);
        axiWr(8'h40, 32'h0000_0001, r);
        cmpResp(r, 2'b10);
        axiRd(8'h40, d, r);
        cmpResp(r, 2'b10);
        wr(CT, 32'h0000_0001);
        rdChk(CT, 32'hFFFF_FFFF, 32'h0000_0080);
        wr(`FPE_OFF_MAIN_KEY, K1);
        wr(`FPE_OFF_MAIN_KEY, K2);
        rdChk(CT, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(`FPE_OFF_OPT_KEY, K1);
        wr(`FPE_OFF_OPT_KEY, K2);
        rdChk(CT, 32'h0000_0200, 32'h0000_0200);
        wr(CT, 32'h0000_0000);
        rdChk(CT, 32'h0000_0200, 32'h0000_0000);
        cfgMismatch <= 1;
        repeat (2) @(posedge clk);
        rdChk(ST, 32'h0000_0300, 32'h0000_0200);
        cfgMismatch <= 0;
        patternMismatch <= 1;
        repeat (2) @(posedge clk);
        rdChk(ST, 32'h0000_0300, 32'h0000_0100);
        patternMismatch <= 0;
        $display("test registers done");
    endtask : testRegs
    task automatic testProgram();
        wr(CT, 32'h0000_0001);
        progTry(32'h0000_0100, 32'h0000_0011);
        rdChk(ST, 32'h0000_0015, 32'h0000_0010);
        cmpWord({31'h0, errIrq}, 0);
        wr(CT, 32'h0000_0401);
        cmpWord({31'h0, errIrq}, 1);
        wr(ST, 32'h0000_0010);
        rdChk(ST, 32'h0000_0014, 32'h0000_0000);
        progTry(32'h0000_000C, 32'h0000_0022);
        rdChk(ST, 32'h0000_0005, 32'h0000_0004);
        cmpWord({31'h0, errIrq}, 1);
        wr(ST, 32'h0000_0004);
        rdChk(ST, 32'h0000_0004, 32'h0000_0000);
        progTry(32'h0000_0010, 32'h0000_5A5A);
        rdChk(ST, 32'h0000_0001, 32'h0000_0001);
        waitIdle();
        rdChk(ST, 32'h0000_0035, 32'h0000_0020);
        cmpWord(flash.mem[4], 32'h0000_5A5A);
        wr(ST, 32'h0000_0020);
        $display("test program done");
    endtask : testProgram
    task automatic testErase();
        logic [31:0] mode [3] = '{32'h0000_0002, 32'h0000_0100, 32'h0000_0004};
        int pages [3] = '{1, 48, 64};
        int t0;
        for (int i = 0; i < 3; i++)
        begin
            wr(CT, 32'h0000_1000 | mode[i]);
            t0 = eraseCycles;
            wr(CT, 32'h0000_1040 | mode[i]);
            rdChk(ST, 32'h0000_0001, 32'h0000_0001);
            rdChk(CT, 32'h0000_0040, 32'h0000_0000);
            waitIdle();
            rdChk(ST, 32'h0000_0021, 32'h0000_0020);
            cmpWord(eraseCycles - t0, `FPE_ERASE_CYC * pages[i]);
            cmpWord({31'h0, doneIrq}, 1);
            wr(ST, 32'h0000_0020);
            rdChk(ST, 32'h0000_0020, 32'h0000_0000);
        end
        wr(`FPE_OFF_OPT_KEY, K1);
        wr(`FPE_OFF_OPT_KEY, K2);
        wr(CT, 32'h0000_1260);
        rdChk(ST, 32'h0000_0001, 32'h0000_0001);
        cmpWord({31'h0, arrayOpt}, 1);
        wr(`FPE_OFF_ADDRESS, 32'h0000_0200);
        rdChk(`FPE_OFF_ADDRESS, 32'hFFFF_FFFF, 32'h0000_0010);
        waitIdle();
        rdChk(ST, 32'h0000_0021, 32'h0000_0020);
        wr(ST, 32'h0000_0020);
        wr(CT, 32'h0000_0080);
        wr(`FPE_OFF_MAIN_KEY, K2);
        wr(`FPE_OFF_MAIN_KEY, K1);
        wr(`FPE_OFF_MAIN_KEY, K2);
        rdChk(CT, 32'h0000_0080, 32'h0000_0080);
        $display("test erase and lock done");
    endtask : testErase
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        testRegs();
        testProgram();
        testErase();
        summarize();
    end
endmodule : tb_top
